// [core/pfp_pkg.sv]
// package for the process feedback and regulator front end: map, fields, codes, timing
package pfp_pkg;

  // clock and control sample timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_CYCLES_RAW = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLES = (SAMPLE_CYCLES_RAW < 1) ? 1 : SAMPLE_CYCLES_RAW;

  // gain is held in hundredths, 0.00 .. 10.00
  localparam int GAIN_SCALE = 100;
  localparam int GAIN_MAX = 1000;
  localparam int GAIN_W = 10;
  localparam logic [9:0] GAIN_RESET = 10'h001;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SETPOINT1 = 8'h04;
  localparam logic [7:0] ADDR_SETPOINT2 = 8'h08;
  localparam logic [7:0] ADDR_REF_MIN = 8'h0C;
  localparam logic [7:0] ADDR_REF_MAX = 8'h10;
  localparam logic [7:0] ADDR_BUS_FB1 = 8'h14;
  localparam logic [7:0] ADDR_BUS_FB2 = 8'h18;
  localparam logic [7:0] ADDR_HANDOVER = 8'h1C;
  localparam logic [7:0] ADDR_GAIN = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_FEEDBACK = 8'h28;
  localparam logic [7:0] ADDR_ERROR = 8'h2C;

  // feedback combining modes
  typedef enum logic [3:0] {
    MODE_MIN = 4'h0,
    MODE_MAX = 4'h1,
    MODE_SUM = 4'h2,
    MODE_DIFF = 4'h3,
    MODE_AVG = 4'h4,
    MODE_ZONE_MIN = 4'h5,
    MODE_ZONE_MAX = 4'h6,
    MODE_FB1_ONLY = 4'h7,
    MODE_FB2_ONLY = 4'h8
  } pfp_mode_t;

  // control register layout, bits [7:0]
  typedef struct packed {
    logic [3:0] dual_feedback_combine_mode;
    logic integrator_clamp_enable;
    logic regulation_sense_select;
    logic feedback_transform_select;
    logic closed_loop_config;
  } pfp_ctrl_t;

  localparam int CTRL_W = 8;
  localparam pfp_ctrl_t CTRL_RESET = '{dual_feedback_combine_mode: 4'h1, integrator_clamp_enable: 1'b1,
    regulation_sense_select: 1'b0, feedback_transform_select: 1'b0, closed_loop_config: 1'b1};

  // start-up sequencer, gray along idle -> ramp -> closed
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_CLOSED = 2'b11
  } pfp_state_t;

  // status register layout, bits [3:0]
  typedef struct packed {
    logic held;
    logic engaged;
    logic [1:0] state;
  } pfp_status_t;

  localparam int STATUS_W = 4;

endpackage : pfp_pkg

// [core/pfp_regulator.sv]
// process feedback conditioning, setpoint selection, start-up hand-over and proportional/integral core
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps

// Function
// - code 0 passes feedback linearly; code 1 takes its square root.
// - channel one is bus value one plus input one; likewise channel two.
// - mode 0 regulates on the lower of the two channels.
// - mode 1, the reset default, regulates on the higher channel.
// - mode 2 regulates on the channel sum, remote reference added to setpoint one.
// - mode 3 regulates on channel two minus channel one.
// - mode 4 regulates on the channel mean, remote reference added to setpoint one.
// - mode 5 picks the zone with the larger signed error.
// - mode 6 picks the zone with the smaller signed error.
// - mode 7 uses input one only, against setpoint one.
// - mode 8 uses input two only, against setpoint two.
// - setpoint one, clamped to reference limits, reset zero, is the closed-loop reference.
// - setpoint two is used only in closed loop with a two-zone mode or mode 8.
// - sense code 0 lowers frequency as feedback rises; code 1 raises it.
// - with clamp on, any limit reloads the integrator to the actual frequency.
// - after such a hold the regulator waits for zero or sign-changed deviation.
// - with clamp off the integrator keeps integrating and must unwind later.
// - start ramps open loop to the hand-over frequency, then closes the loop.
// - at current limit before hand-over the regulator stays off until lowered.
// - the hand-over frequency is always applied clockwise.
// - deviation is multiplied by the gain, 0.00 to 10.00, default 0.01.
module pfp_regulator #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [31:0] rd_data_out,
  // analogue feedback and remote reference
  input wire logic [DATA_W-1:0] analog_fb1_in,
  input wire logic [DATA_W-1:0] analog_fb2_in,
  input wire logic signed [DATA_W-1:0] remote_ref_in,
  // drive state
  input wire logic start_cmd_in,
  input wire logic dir_cw_in,
  input wire logic [DATA_W-1:0] output_freq_in,
  input wire logic current_limit_in,
  input wire logic voltage_limit_in,
  input wire logic freq_max_in,
  input wire logic freq_min_in,
  // regulator results
  output logic [DATA_W-1:0] freq_request_out,
  output logic dir_cw_out,
  output logic closed_loop_out,
  output logic engaged_out,
  output logic sample_tick_out
);

  localparam int EW = DATA_W + 3;
  localparam int AW = EW + 16;
  localparam logic [DATA_W-1:0] ALL_ONES = '1;

  // refuse widths the arithmetic cannot hold
  initial begin
    if (DATA_W < 8 || DATA_W > 24) begin
      $error("pfp_regulator: DATA_W must lie in 8..24");
    end
  end

  // integer square root of a 2W-bit value, W-bit result
  function automatic logic [DATA_W-1:0] isqrt(input logic [2*DATA_W-1:0] x);
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] trial;
    logic [2*DATA_W-1:0] sq;
    res = '0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      trial = res | (DATA_W'(1) << i);
      sq = trial * trial;
      if (sq <= x) begin
        res = trial;
      end
    end
    return res;
  endfunction : isqrt

  // zero-extend an unsigned value into the signed error width
  function automatic logic signed [EW-1:0] uext(input logic [DATA_W-1:0] v);
    return signed'({3'b000, v});
  endfunction : uext

  // software-visible state
  pfp_pkg::pfp_ctrl_t ctrl_reg;
  logic [DATA_W-1:0] setpoint1_reg;
  logic [DATA_W-1:0] setpoint2_reg;
  logic [DATA_W-1:0] ref_min_reg;
  logic [DATA_W-1:0] ref_max_reg;
  logic [DATA_W-1:0] bus_fb1_reg;
  logic [DATA_W-1:0] bus_fb2_reg;
  logic [DATA_W-1:0] handover_frequency_reg;
  logic [pfp_pkg::GAIN_W-1:0] proportional_factor_reg;

  // sampled results and regulator state
  logic signed [EW-1:0] feedback_reg;
  logic signed [EW-1:0] error_reg;
  logic signed [AW-1:0] integ_reg;
  logic held_reg;
  logic held_sign_reg;
  pfp_pkg::pfp_state_t state_reg;
  pfp_pkg::pfp_state_t state_next;
  logic [15:0] tick_cnt_reg;
  logic tick_reg;

  // sample period divider: one-cycle enable
  wire tick_wrap = (tick_cnt_reg == 16'(pfp_pkg::SAMPLE_CYCLES - 1));
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? 16'h0000 : tick_cnt_reg + 16'h0001;
      tick_reg <= tick_wrap;
    end
  end

  // write decode; an out-of-range mode code leaves the old mode in place
  wire wr_ctrl = wr_strobe_in && (addr_in == pfp_pkg::ADDR_CTRL);
  wire mode_legal = (wr_data_in[7:4] <= 4'h8);
  wire [3:0] mode_wr = mode_legal ? wr_data_in[7:4] : ctrl_reg.dual_feedback_combine_mode;
  wire [DATA_W-1:0] wr_word = wr_data_in[DATA_W-1:0];
  wire wr_gain = wr_strobe_in && (addr_in == pfp_pkg::ADDR_GAIN);
  wire gain_legal = (wr_data_in <= 32'(pfp_pkg::GAIN_MAX));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_reg <= pfp_pkg::CTRL_RESET;
      setpoint1_reg <= '0;
      setpoint2_reg <= '0;
      ref_min_reg <= '0;
      ref_max_reg <= '1;
      bus_fb1_reg <= '0;
      bus_fb2_reg <= '0;
      handover_frequency_reg <= '0;
      proportional_factor_reg <= pfp_pkg::GAIN_RESET;
    end else if (wr_strobe_in) begin
      if (wr_ctrl) begin
        ctrl_reg <= pfp_pkg::pfp_ctrl_t'({mode_wr, wr_data_in[3:0]});
      end
      if (addr_in == pfp_pkg::ADDR_SETPOINT1) setpoint1_reg <= wr_word;
      if (addr_in == pfp_pkg::ADDR_SETPOINT2) setpoint2_reg <= wr_word;
      if (addr_in == pfp_pkg::ADDR_REF_MIN) ref_min_reg <= wr_word;
      if (addr_in == pfp_pkg::ADDR_REF_MAX) ref_max_reg <= wr_word;
      if (addr_in == pfp_pkg::ADDR_BUS_FB1) bus_fb1_reg <= wr_word;
      if (addr_in == pfp_pkg::ADDR_BUS_FB2) bus_fb2_reg <= wr_word;
      if (addr_in == pfp_pkg::ADDR_HANDOVER) handover_frequency_reg <= wr_word;
      if (wr_gain && gain_legal) proportional_factor_reg <= wr_data_in[pfp_pkg::GAIN_W-1:0];
    end
  end

  // feedback channels: bus value plus analogue input, single-channel modes mute the other input
  wire [3:0] mode = ctrl_reg.dual_feedback_combine_mode;
  wire mode_fb1_only = (mode == pfp_pkg::MODE_FB1_ONLY);
  wire mode_fb2_only = (mode == pfp_pkg::MODE_FB2_ONLY);
  wire [DATA_W-1:0] analog1_used = mode_fb2_only ? '0 : analog_fb1_in;
  wire [DATA_W-1:0] analog2_used = mode_fb1_only ? '0 : analog_fb2_in;
  wire [DATA_W:0] fb1_raw = {1'b0, bus_fb1_reg} + {1'b0, analog1_used};
  wire [DATA_W:0] fb2_raw = {1'b0, bus_fb2_reg} + {1'b0, analog2_used};
  // saturate rather than wrap so an overflowing sum still reads as high feedback
  wire [DATA_W-1:0] fb1_sat = fb1_raw[DATA_W] ? ALL_ONES : fb1_raw[DATA_W-1:0];
  wire [DATA_W-1:0] fb2_sat = fb2_raw[DATA_W] ? ALL_ONES : fb2_raw[DATA_W-1:0];

  // square-root transform keeps full scale: sqrt(x * 2^W) maps full scale to full scale
  wire sqrt_on = ctrl_reg.feedback_transform_select;
  wire [DATA_W-1:0] fb1 = sqrt_on ? isqrt({fb1_sat, DATA_W'(0)}) : fb1_sat;
  wire [DATA_W-1:0] fb2 = sqrt_on ? isqrt({fb2_sat, DATA_W'(0)}) : fb2_sat;

  // setpoints bounded by the reference limits
  wire [DATA_W-1:0] sp1_lo = (setpoint1_reg < ref_min_reg) ? ref_min_reg : setpoint1_reg;
  wire [DATA_W-1:0] sp1 = (sp1_lo > ref_max_reg) ? ref_max_reg : sp1_lo;
  wire [DATA_W-1:0] sp2_lo = (setpoint2_reg < ref_min_reg) ? ref_min_reg : setpoint2_reg;
  wire [DATA_W-1:0] sp2 = (sp2_lo > ref_max_reg) ? ref_max_reg : sp2_lo;

  // zone errors; signed compare puts every positive error above every negative one
  wire signed [EW-1:0] zone1_err = uext(sp1) - uext(fb1);
  wire signed [EW-1:0] zone2_err = uext(sp2) - uext(fb2);
  wire zone2_larger = (zone2_err > zone1_err);
  wire zone2_smaller = (zone2_err < zone1_err);

  // channel arithmetic for the combining modes
  wire signed [EW-1:0] fb_min = (fb1 < fb2) ? uext(fb1) : uext(fb2);
  wire signed [EW-1:0] fb_max = (fb1 > fb2) ? uext(fb1) : uext(fb2);
  wire signed [EW-1:0] fb_sum = uext(fb1) + uext(fb2);
  wire signed [EW-1:0] fb_diff = uext(fb2) - uext(fb1);
  wire signed [EW-1:0] fb_avg = fb_sum >>> 1;

  // mode selection of feedback and of the setpoint that takes the remote reference
  logic signed [EW-1:0] fb_sel;
  logic use_sp2;
  always_comb begin
    fb_sel = fb_max;
    use_sp2 = 1'b0;
    unique case (mode)
      pfp_pkg::MODE_MIN: fb_sel = fb_min;
      pfp_pkg::MODE_MAX: fb_sel = fb_max;
      pfp_pkg::MODE_SUM: fb_sel = fb_sum;
      pfp_pkg::MODE_DIFF: fb_sel = fb_diff;
      pfp_pkg::MODE_AVG: fb_sel = fb_avg;
      pfp_pkg::MODE_ZONE_MIN: begin
        use_sp2 = zone2_larger;
        fb_sel = zone2_larger ? uext(fb2) : uext(fb1);
      end
      pfp_pkg::MODE_ZONE_MAX: begin
        use_sp2 = zone2_smaller;
        fb_sel = zone2_smaller ? uext(fb2) : uext(fb1);
      end
      pfp_pkg::MODE_FB1_ONLY: fb_sel = uext(fb1);
      pfp_pkg::MODE_FB2_ONLY: begin
        use_sp2 = 1'b1;
        fb_sel = uext(fb2);
      end
      default: fb_sel = fb_max; // writes guard the code, kept for safety
    endcase
  end

  // second setpoint only in closed loop; remote reference rides on the chosen one
  wire sp2_active = use_sp2 && ctrl_reg.closed_loop_config;
  wire [DATA_W-1:0] sp_sel = sp2_active ? sp2 : sp1;
  wire signed [EW-1:0] rr_ext = EW'(remote_ref_in);
  wire signed [EW-1:0] reference = uext(sp_sel) + rr_ext;
  wire signed [EW-1:0] err_raw = reference - fb_sel;
  wire signed [EW-1:0] err_sensed = ctrl_reg.regulation_sense_select ? -err_raw : err_raw;

  // proportional term and integrator arithmetic, all in hundredths of a frequency count
  wire signed [AW-1:0] err_ext = AW'(err_sensed);
  wire signed [AW-1:0] gain_ext = signed'(AW'({1'b0, proportional_factor_reg}));
  wire signed [AW-1:0] p_term = AW'(err_ext * gain_ext);
  wire signed [AW-1:0] actual_hund = AW'(signed'({1'b0, output_freq_in}) * pfp_pkg::GAIN_SCALE);
  wire signed [AW-1:0] reg_sum = integ_reg + p_term;
  wire signed [AW-1:0] reg_freq = reg_sum / AW'(pfp_pkg::GAIN_SCALE);
  wire freq_over = (reg_freq > signed'(AW'({1'b0, ALL_ONES})));
  wire [DATA_W-1:0] reg_freq_clip = reg_sum[AW-1] ? '0 : (freq_over ? ALL_ONES : reg_freq[DATA_W-1:0]);

  // limit detection and hold release
  wire limit_any = current_limit_in || voltage_limit_in || freq_max_in || freq_min_in;
  wire clamp_on = ctrl_reg.integrator_clamp_enable;
  wire err_zero = (err_sensed == '0);
  wire err_sign = err_sensed[EW-1];
  wire hold_release = err_zero || (err_sign != held_sign_reg);
  wire handover_reached = (output_freq_in >= handover_frequency_reg);

  // start-up sequencer: open-loop ramp to hand-over, then closed loop
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pfp_pkg::ST_IDLE: begin
        if (start_cmd_in && ctrl_reg.closed_loop_config) state_next = pfp_pkg::ST_RAMP;
      end
      pfp_pkg::ST_RAMP: begin
        if (!start_cmd_in || !ctrl_reg.closed_loop_config) begin
          state_next = pfp_pkg::ST_IDLE;
        end else if (handover_reached && !current_limit_in) begin
          state_next = pfp_pkg::ST_CLOSED;
        end
      end
      pfp_pkg::ST_CLOSED: begin
        if (!start_cmd_in || !ctrl_reg.closed_loop_config) state_next = pfp_pkg::ST_IDLE;
      end
      default: state_next = pfp_pkg::ST_IDLE;
    endcase
  end

  // sampled feedback and error, updated once per sample period
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      feedback_reg <= '0;
      error_reg <= '0;
      state_reg <= pfp_pkg::ST_IDLE;
    end else if (tick_reg) begin
      feedback_reg <= fb_sel;
      error_reg <= err_sensed;
      state_reg <= state_next;
    end
  end

  // integrator: reload on hand-over and on limits, else accumulate unless held
  wire entering_closed = (state_reg == pfp_pkg::ST_RAMP) && (state_next == pfp_pkg::ST_CLOSED);
  wire in_closed = (state_reg == pfp_pkg::ST_CLOSED);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      integ_reg <= '0;
      held_reg <= 1'b0;
      held_sign_reg <= 1'b0;
    end else if (tick_reg) begin
      if (entering_closed) begin
        integ_reg <= actual_hund; // bumpless start from the ramp
        held_reg <= 1'b0;
      end else if (in_closed && clamp_on && limit_any) begin
        integ_reg <= actual_hund;
        held_reg <= 1'b1;
        held_sign_reg <= err_sign;
      end else if (in_closed && held_reg) begin
        if (hold_release) held_reg <= 1'b0;
      end else if (in_closed) begin
        integ_reg <= integ_reg + err_ext;
      end
    end
  end

  // drive outputs; a held regulator follows the actual frequency
  logic [DATA_W-1:0] freq_next;
  always_comb begin
    freq_next = '0;
    unique case (state_reg)
      pfp_pkg::ST_IDLE: freq_next = '0;
      pfp_pkg::ST_RAMP: freq_next = handover_frequency_reg;
      pfp_pkg::ST_CLOSED: freq_next = held_reg ? output_freq_in : reg_freq_clip;
      default: freq_next = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      freq_request_out <= '0;
      dir_cw_out <= 1'b1;
      closed_loop_out <= 1'b0;
      engaged_out <= 1'b0;
    end else begin
      freq_request_out <= freq_next;
      dir_cw_out <= (state_reg == pfp_pkg::ST_RAMP) ? 1'b1 : dir_cw_in;
      closed_loop_out <= in_closed;
      engaged_out <= in_closed && !held_reg;
    end
  end

  assign sample_tick_out = tick_reg;

  // read decode; unmapped addresses read as zero
  pfp_pkg::pfp_status_t status;
  assign status = '{held: held_reg, engaged: in_closed && !held_reg, state: state_reg};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_in)
      pfp_pkg::ADDR_CTRL: rd_mux = 32'(ctrl_reg);
      pfp_pkg::ADDR_SETPOINT1: rd_mux = 32'(setpoint1_reg);
      pfp_pkg::ADDR_SETPOINT2: rd_mux = 32'(setpoint2_reg);
      pfp_pkg::ADDR_REF_MIN: rd_mux = 32'(ref_min_reg);
      pfp_pkg::ADDR_REF_MAX: rd_mux = 32'(ref_max_reg);
      pfp_pkg::ADDR_BUS_FB1: rd_mux = 32'(bus_fb1_reg);
      pfp_pkg::ADDR_BUS_FB2: rd_mux = 32'(bus_fb2_reg);
      pfp_pkg::ADDR_HANDOVER: rd_mux = 32'(handover_frequency_reg);
      pfp_pkg::ADDR_GAIN: rd_mux = 32'(proportional_factor_reg);
      pfp_pkg::ADDR_STATUS: rd_mux = 32'(status);
      pfp_pkg::ADDR_FEEDBACK: rd_mux = 32'(feedback_reg);
      pfp_pkg::ADDR_ERROR: rd_mux = 32'(error_reg);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= rd_strobe_in ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : pfp_regulator

// [dv/pfp_regulator_props.sv]
// port checker for the regulator: tick spacing, read data, start-up hand-over
`timescale 1ns/10ps
module pfp_regulator_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port and drive state
  input wire logic [7:0] addr_in,
  input wire logic rd_strobe_in,
  input wire logic [31:0] rd_data_out,
  input wire logic start_cmd_in,
  input wire logic current_limit_in,
  // regulator results
  input wire logic closed_loop_out,
  input wire logic engaged_out,
  input wire logic sample_tick_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  localparam logic [7:0] LAST_GAP = 8'(pfp_pkg::SAMPLE_CYCLES - 1);
  logic [7:0] gap_reg;
  logic seen_reg, tick1_reg, tick2_reg, lim1_reg, lim2_reg;
  // outputs may land one or two cycles after the tick, so both delays are kept
  always_ff @(posedge clk_in) begin
    gap_reg <= (reset_in || sample_tick_out) ? 8'h00 : gap_reg + 8'h01;
    seen_reg <= !reset_in && (seen_reg || sample_tick_out);
    tick1_reg <= sample_tick_out;
    tick2_reg <= tick1_reg;
    lim1_reg <= current_limit_in;
    lim2_reg <= lim1_reg;
  end
  wire after_tick = tick1_reg || tick2_reg;
  wire limit_at_tick = (tick1_reg && lim1_reg) || (tick2_reg && lim2_reg);
  tick_period_a: assert property (sample_tick_out && seen_reg |-> gap_reg == LAST_GAP)
    else $error("sample tick spacing wrong");
  read_quiet_a: assert property (rd_data_out != 32'h0 |-> $past(rd_strobe_in))
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property (rd_strobe_in && (addr_in[1:0] != 2'h0 || addr_in > 8'h2C) |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  close_on_tick_a: assert property ($changed(closed_loop_out) |-> after_tick)
    else $error("loop state moved off the tick");
  engage_on_tick_a: assert property ($changed(engaged_out) |-> after_tick)
    else $error("engage moved off the tick");
  limit_blocks_a: assert property ($rose(closed_loop_out) |-> !limit_at_tick)
    else $error("loop closed at current limit");
  engaged_closed_a: assert property (engaged_out |-> closed_loop_out)
    else $error("engaged outside closed loop");
  close_needs_start_a: assert property ($rose(closed_loop_out) |-> $past(start_cmd_in, 2))
    else $error("loop closed without start");
  cover property ($rose(closed_loop_out));
  cover property ($fell(engaged_out) && closed_loop_out);
  cover property (rd_strobe_in ##1 rd_data_out != 32'h0);
endmodule : pfp_regulator_props

bind pfp_regulator pfp_regulator_props chk_u (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
  .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out), .start_cmd_in(start_cmd_in),
  .current_limit_in(current_limit_in), .closed_loop_out(closed_loop_out), .engaged_out(engaged_out),
  .sample_tick_out(sample_tick_out));

// [dv/pfp_regulator_tb.sv]
// self-checking bench for the process feedback regulator
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module pfp_regulator_tb;
  logic clk_in = 1'b0, reset_in = 1'b1, wr_strobe_in = 1'b0, rd_strobe_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0, rd_data_out;
  logic [15:0] fb1, fb2, lvl1 = 16'h0, lvl2 = 16'h0, output_freq_in = 16'h0, freq_request_out;
  logic signed [15:0] remote_ref_in = 16'sh0;
  logic start_cmd_in = 1'b0, dir_cw_in = 1'b1, current_limit_in = 1'b0, voltage_limit_in = 1'b0;
  logic freq_max_in = 1'b0, freq_min_in = 1'b0, dir_cw_out, closed_loop_out, engaged_out, sample_tick_out;
  int errors = 0, compares = 0;
  integer seed = 32'hf6a914da;
  pfp_regulator dut_u (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out), .analog_fb1_in(fb1),
    .analog_fb2_in(fb2), .remote_ref_in(remote_ref_in), .start_cmd_in(start_cmd_in), .dir_cw_in(dir_cw_in),
    .output_freq_in(output_freq_in), .current_limit_in(current_limit_in), .voltage_limit_in(voltage_limit_in),
    .freq_max_in(freq_max_in), .freq_min_in(freq_min_in), .freq_request_out(freq_request_out),
    .dir_cw_out(dir_cw_out), .closed_loop_out(closed_loop_out), .engaged_out(engaged_out),
    .sample_tick_out(sample_tick_out));
  pfp_xmtr xmtr_u (.clk_in(clk_in), .level1_in(lvl1), .level2_in(lvl2), .analog_fb1_out(fb1),
    .analog_fb2_out(fb2));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // bus cycles: one strobe cycle each, read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_strobe_in <= 1'b1;
    @(posedge clk_in);
    wr_strobe_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_strobe_in <= 1'b1;
    @(posedge clk_in);
    rd_strobe_in <= 1'b0;
    #1 d = rd_data_out;
    @(posedge clk_in);
  endtask : rd
  // waits for n sample ticks, bounded, then lets the registered results settle
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk_in);
        #1 k++;
      end while (sample_tick_out !== 1'b1 && k < 200);
      if (k >= 200) begin
        errors++;
        give_verdict();
      end
      repeat (3) @(posedge clk_in);
    end
  endtask : ticks
  function automatic logic [31:0] ctrl(input int m, input int inv, input int sq);
    return {24'h0, 4'(m), 1'b1, 1'(inv), 1'(sq), 1'b1};
  endfunction : ctrl
  function automatic int exp_fb(input int m, input int f1, input int f2);
    case (m)
      0: return (f1 < f2) ? f1 : f2;
      1: return (f1 > f2) ? f1 : f2;
      2: return f1 + f2;
      3: return f2 - f1;
      4: return (f1 + f2) / 2;
      8: return f2;
      default: return f1;
    endcase
  endfunction : exp_fb
  // zone modes compare signed errors; ties go to zone one
  function automatic int exp_err(input int m, input int s1, input int s2, input int r, input int f1, input int f2);
    int e1, e2;
    e1 = s1 + r - f1;
    e2 = s2 + r - f2;
    case (m)
      5: return (e2 > e1) ? e2 : e1;
      6: return (e2 < e1) ? e2 : e1;
      8: return e2;
      default: return s1 + r - exp_fb(m, f1, f2);
    endcase
  endfunction : exp_err
  initial begin
    logic [31:0] d;
    static logic [7:0] ra[7] = '{8'h00, 8'h20, 8'h04, 8'h08, 8'h1C, 8'h10, 8'h31};
    static logic [31:0] rv[7] = '{32'h19, 32'h1, 32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0};
    int m, inv, b1, b2, l1, l2, s1, s2, r, e;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      `CHK("reset value", rv[i], d)
    end
    wr(pfp_pkg::ADDR_GAIN, 32'h3E9);
    rd(pfp_pkg::ADDR_GAIN, d);
    `CHK("gain over range", 32'h1, d)
    wr(pfp_pkg::ADDR_GAIN, 32'h3E8);
    rd(pfp_pkg::ADDR_GAIN, d);
    `CHK("gain full scale", 32'h3E8, d)
    $display("test registers done");
    // random mix walks every combining mode twice
    for (int i = 0; i < 18; i++) begin
      m = i % 9;
      inv = (m < 5) ? ($random(seed) & 1) : 0;
      b1 = $random(seed) & 32'hFFF;
      b2 = $random(seed) & 32'hFFF;
      l1 = $random(seed) & 32'h1FFF;
      l2 = $random(seed) & 32'h1FFF;
      s1 = $random(seed) & 32'h3FFF;
      s2 = (i == 14) ? s1 : ($random(seed) & 32'h3FFF);
      r = ($random(seed) & 32'hFFF) - 2048;
      lvl1 <= 16'(l1);
      lvl2 <= 16'(l2);
      remote_ref_in <= 16'(r);
      wr(pfp_pkg::ADDR_BUS_FB1, 32'(b1));
      wr(pfp_pkg::ADDR_BUS_FB2, 32'(b2));
      wr(pfp_pkg::ADDR_SETPOINT1, 32'(s1));
      wr(pfp_pkg::ADDR_SETPOINT2, 32'(s2));
      wr(pfp_pkg::ADDR_CTRL, ctrl(m, inv, 0)); // square root stays off in every combining mode
      ticks(1);
      e = exp_err(m, s1, s2, r, b1 + l1, b2 + l2);
      e = inv ? -e : e;
      if (m != 5 && m != 6) begin
        rd(pfp_pkg::ADDR_FEEDBACK, d);
        `CHK("feedback", 19'(exp_fb(m, b1 + l1, b2 + l2)), d[18:0])
      end
      rd(pfp_pkg::ADDR_ERROR, d);
      `CHK("error", 19'(e), d[18:0])
    end
    $display("test combine done");
    // setpoint above the upper reference limit is clamped
    wr(pfp_pkg::ADDR_REF_MAX, 32'h800);
    wr(pfp_pkg::ADDR_SETPOINT1, 32'h1000);
    wr(pfp_pkg::ADDR_BUS_FB1, 32'h0);
    wr(pfp_pkg::ADDR_CTRL, ctrl(7, 0, 0));
    lvl1 <= 16'h0100;
    remote_ref_in <= 16'sh0;
    ticks(1);
    rd(pfp_pkg::ADDR_ERROR, d);
    `CHK("clamped error", 19'h700, d[18:0])
    wr(pfp_pkg::ADDR_REF_MAX, 32'hFFFF);
    wr(pfp_pkg::ADDR_CTRL, ctrl(7, 0, 1));
    lvl1 <= 16'h4000;
    ticks(1);
    rd(pfp_pkg::ADDR_FEEDBACK, d);
    `CHK("square root", 19'h8000, d[18:0])
    $display("test clamp and root done");
    // start-up: ramp counter-clockwise request, current limit blocks hand-over
    wr(pfp_pkg::ADDR_CTRL, ctrl(7, 0, 0));
    wr(pfp_pkg::ADDR_SETPOINT1, 32'h3E8);
    wr(pfp_pkg::ADDR_HANDOVER, 32'h1F40);
    lvl1 <= 16'h03E8;
    dir_cw_in <= 1'b0;
    output_freq_in <= 16'h0FA0;
    current_limit_in <= 1'b1;
    start_cmd_in <= 1'b1;
    ticks(2);
    `CHK("ramp request", 16'h1F40, freq_request_out)
    `CHK("ramp direction", 1'b1, dir_cw_out)
    output_freq_in <= 16'h1F40;
    ticks(2);
    `CHK("blocked at limit", 1'b0, closed_loop_out)
    wr(pfp_pkg::ADDR_HANDOVER, 32'h1770);
    current_limit_in <= 1'b0;
    ticks(2);
    `CHK("loop closed", 1'b1, closed_loop_out)
    `CHK("engaged", 1'b1, engaged_out)
    `CHK("zero error request", 16'h1F40, freq_request_out)
    $display("test start-up done");
    // sense, then hold at the frequency limit and release on sign change
    lvl1 <= 16'h04B0;
    ticks(3);
    `CHK("normal sense", 1'b1, freq_request_out < 16'h1F40)
    wr(pfp_pkg::ADDR_CTRL, ctrl(7, 1, 0));
    ticks(3);
    `CHK("inverse sense", 1'b1, freq_request_out > 16'h1F40)
    freq_max_in <= 1'b1;
    ticks(2);
    `CHK("held engage", 1'b0, engaged_out)
    `CHK("held request", 16'h1F40, freq_request_out)
    freq_max_in <= 1'b0;
    ticks(2);
    `CHK("still held", 1'b0, engaged_out)
    lvl1 <= 16'h0320;
    ticks(2);
    `CHK("released", 1'b1, engaged_out)
    wr(pfp_pkg::ADDR_CTRL, 32'h75);
    freq_min_in <= 1'b1;
    ticks(2);
    `CHK("unclamped", 1'b1, engaged_out)
    start_cmd_in <= 1'b0;
    ticks(2);
    `CHK("stopped", 1'b0, closed_loop_out)
    $display("test sense and hold done");
    give_verdict();
  end
endmodule : pfp_regulator_tb

// [dv/pfp_xmtr.sv]
// process transmitter model feeding the two analogue feedback inputs
`timescale 1ns/10ps
module pfp_xmtr (
  // clock
  input wire logic clk_in,
  // process levels chosen by the bench
  input wire logic [15:0] level1_in,
  input wire logic [15:0] level2_in,
  // analogue feedback toward the regulator
  output logic [15:0] analog_fb1_out,
  output logic [15:0] analog_fb2_out
);
  // one cycle of converter lag, never a level in the cycle it is set
  always_ff @(posedge clk_in) begin
    analog_fb1_out <= level1_in;
    analog_fb2_out <= level2_in;
  end
endmodule : pfp_xmtr
